// File: logic/pcg_clock_gating.sv
// Peripheral clock gating with Stop mode keep bits behind an APB slave.
//
// Contract
// [RULE1] Enable bit 10 gates converter clock.
// [RULE2] Enable bit 6 gates two-wire clock.
// [RULE3] Bits 5,4 gate async ports 1,0.
// [RULE4] Bits 3,2 gate sync ports 1,0.
// [RULE5] Enable bit 0 gates modulator clock.
// [RULE6] Software writes zero to bits 9-7, 1.
// [RULE7] Second register bits 14-12 gate interval timers.
// [RULE8] Bits 7-4 gate timer B channels.
// [RULE9] Bits 3-0 gate timer A channels.
// [RULE10] Software writes zero to bits 15, 11-8.
// [RULE11] Clocks stop in Stop unless keep set.
// [RULE12] Keep works only with enable also set.
// [RULE13] Interrupt from clocked peripheral wakes to Run.
// [RULE14] Disabled module ignores reads and writes.
// [RULE15] Software disables unkept peripherals before Stop.
// [RULE16] Software keeps few peripherals running in Stop.
// [RULE17] Keep bits 15-12: comparators, analog outputs.
// [RULE18] Keep bits 10,6,5,4,3 mapped as enables.
// [RULE19] Enable bits 15-12 gate comparators, analog outputs.
// [RULE20] Keep bits 2,0: sync port 0, modulator.
// [RULE21] All fields clear to zero on reset.
`timescale 1ns/1ps
module pcg_clock_gating
    import pcg_pkg::*;
(
    // Clock and reset.
    input  wire logic              core_clk,
    input  wire logic              sys_rst,
    // APB slave.
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Stop request from the core.
    input  wire logic              stop_req,
    // Peripheral interrupts, group 1 high, group 0 low.
    input  wire pcg_pair_type      periph_irq,
    // Peripheral access selects from the bus fabric.
    input  wire pcg_pair_type      periph_sel,
    // Gated results.
    output pcg_pair_type           periph_clk_en,
    output pcg_pair_type           periph_sel_gated,
    output logic                   in_stop_mode
);

    ////////////////////////////////////////////////////////////////////////
    // Register storage.
    logic [15:0] peripheral_clock_gate_0;
    logic [15:0] peripheral_clock_gate_1;
    logic [15:0] stop_clock_keep_0;
    logic [15:0] stop_clock_keep_1;
    logic        stop_pulse;
    logic        in_stop;
    logic        pslverr_next_q;

    ////////////////////////////////////////////////////////////////////////
    // Address decode.
    wire         access;
    wire         wr_take;
    wire         rd_take;
    wire [5:0]   reg_idx;
    wire         hit_gate0;
    wire         hit_gate1;
    wire         hit_keep0;
    wire         hit_keep1;
    wire         hit_mode;
    wire         hit_any;
    wire         aligned;
    wire [15:0]  wr_lanes;
    wire [15:0]  wdata16;

    assign access    = psel & penable;
    assign wr_take   = access & pready & pwrite & ~pslverr_next_q;
    assign rd_take   = access & ~pready & ~pwrite;
    assign reg_idx   = paddr[ADDR_W-1:ADDR_LSB];
    assign aligned   = (paddr[ADDR_LSB-1:0] == 2'h0);
    assign hit_gate0 = aligned & (reg_idx == IDX_GATE0);
    assign hit_gate1 = aligned & (reg_idx == IDX_GATE1);
    assign hit_keep0 = aligned & (reg_idx == IDX_KEEP0);
    assign hit_keep1 = aligned & (reg_idx == IDX_KEEP1);
    assign hit_mode  = aligned & (reg_idx == IDX_MODE);
    assign hit_any   = hit_gate0 | hit_gate1 | hit_keep0 | hit_keep1 |
                       hit_mode;
    assign wr_lanes  = {{8{pstrb[1]}}, {8{pstrb[0]}}};
    assign wdata16   = pwdata[15:0];

    ////////////////////////////////////////////////////////////////////////
    // Merge a write into a register by byte lanes and writable mask.
    // Reserved bits are never stored, so they read back as zero even when
    // software ignores the advice to write zeros there.
    function automatic logic [15:0] merge16(
        input logic [15:0] old_val,
        input logic [15:0] new_val,
        input logic [15:0] lanes,
        input logic [15:0] mask
    );
        logic [15:0] take;
        take    = lanes & mask;
        merge16 = (old_val & ~take) | (new_val & take);
    endfunction : merge16

    wire [15:0] next_gate0;
    wire [15:0] next_gate1;
    wire [15:0] next_keep0;
    wire [15:0] next_keep1;

    assign next_gate0 = merge16(peripheral_clock_gate_0, wdata16, wr_lanes,
                                GATE0_MASK); // [RULE6]
    assign next_gate1 = merge16(peripheral_clock_gate_1, wdata16, wr_lanes,
                                GATE1_MASK); // [RULE10]
    assign next_keep0 = merge16(stop_clock_keep_0, wdata16, wr_lanes,
                                KEEP0_MASK);
    assign next_keep1 = merge16(stop_clock_keep_1, wdata16, wr_lanes,
                                KEEP1_MASK);

    ////////////////////////////////////////////////////////////////////////
    // Register writes.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            peripheral_clock_gate_0 <= REG_RESET; // [RULE21]
            peripheral_clock_gate_1 <= REG_RESET;
            stop_clock_keep_0       <= REG_RESET;
            stop_clock_keep_1       <= REG_RESET;
        end else if (wr_take) begin
            if (hit_gate0) begin
                peripheral_clock_gate_0 <= next_gate0; // [RULE19]
            end
            if (hit_gate1) begin
                peripheral_clock_gate_1 <= next_gate1; // [RULE7]
            end
            if (hit_keep0) begin
                stop_clock_keep_0 <= next_keep0; // [RULE17] [RULE18]
            end
            if (hit_keep1) begin
                stop_clock_keep_1 <= next_keep1; // [RULE20]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Stop requests come from the core input or from the mode register.
    wire sw_stop;
    assign sw_stop = wr_take & hit_mode & pstrb[0] &
                     wdata16[BIT_MODE_STOP_REQ];

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            stop_pulse <= 1'b0;
        end else begin
            stop_pulse <= sw_stop | stop_req;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read mux.
    logic [15:0] rd_val;
    always_comb begin
        rd_val = 16'h0000;
        if (hit_gate0) begin
            rd_val = peripheral_clock_gate_0;
        end else if (hit_gate1) begin
            rd_val = peripheral_clock_gate_1;
        end else if (hit_keep0) begin
            rd_val = stop_clock_keep_0;
        end else if (hit_keep1) begin
            rd_val = stop_clock_keep_1;
        end else if (hit_mode) begin
            rd_val[BIT_MODE_IN_STOP] = in_stop;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB answer: one wait state. Data and error are loaded together with
    // pready so that the master samples stable values at the same edge.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pready         <= 1'b0;
            pslverr        <= 1'b0;
            pslverr_next_q <= 1'b0;
            prdata         <= 32'h0000_0000;
        end else if (access & ~pready) begin
            pready         <= 1'b1;
            pslverr        <= ~hit_any;
            pslverr_next_q <= ~hit_any;
            if (rd_take) begin
                prdata <= {16'h0000, rd_val};
            end
        end else begin
            pready         <= 1'b0;
            pslverr        <= 1'b0;
            pslverr_next_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Wake-up: only a peripheral whose clock still runs in Stop can raise
    // an interrupt, so the interrupt is qualified by enable and keep.
    wire [31:0] gate_all;
    wire [31:0] keep_all;
    wire        wake;

    assign gate_all = {peripheral_clock_gate_1, peripheral_clock_gate_0};
    assign keep_all = {stop_clock_keep_1, stop_clock_keep_0};
    assign wake     = |(periph_irq & gate_all & keep_all); // [RULE13]

    pcg_stop_ctrl u_stop (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .stop_go  (stop_pulse),
        .wake     (wake),
        .in_stop  (in_stop)
    );

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            in_stop_mode <= 1'b0;
        end else begin
            in_stop_mode <= in_stop;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Gate bank: one lane per peripheral of both groups.
    wire [31:0] clk_en_all;
    wire [31:0] sel_all;

    pcg_gate_bank #(
        .WIDTH (32)
    ) u_bank (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .gate     (gate_all), // [RULE1] [RULE2] [RULE3] [RULE4] [RULE5]
        .keep     (keep_all), // [RULE8] [RULE9]
        .in_stop  (in_stop),
        .sel_in   (periph_sel),
        .clk_en   (clk_en_all),
        .sel_out  (sel_all)
    );

    assign periph_clk_en    = clk_en_all;
    assign periph_sel_gated = sel_all;

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    a_conv_gate: assert property ( // [RULE1]
        @(posedge core_clk) disable iff (sys_rst)
        (!in_stop && peripheral_clock_gate_0[BIT_ANALOG_CONV]) |=>
        periph_clk_en.grp0[BIT_ANALOG_CONV])
        else $error("converter clock missing while enabled in Run");

    a_two_wire_off: assert property ( // [RULE2]
        @(posedge core_clk) disable iff (sys_rst)
        !peripheral_clock_gate_0[BIT_TWO_WIRE] |=>
        !periph_clk_en.grp0[BIT_TWO_WIRE])
        else $error("two-wire clock runs while disabled");

    a_async_pair: assert property ( // [RULE3]
        @(posedge core_clk) disable iff (sys_rst)
        !in_stop |=>
        periph_clk_en.grp0[BIT_ASYNC_PORT1:BIT_ASYNC_PORT0] ==
        $past(peripheral_clock_gate_0[BIT_ASYNC_PORT1:BIT_ASYNC_PORT0]))
        else $error("async port clocks do not follow their enables");

    a_sync_pair: assert property ( // [RULE4]
        @(posedge core_clk) disable iff (sys_rst)
        !in_stop |=>
        periph_clk_en.grp0[BIT_SYNC_PORT1:BIT_SYNC_PORT0] ==
        $past(peripheral_clock_gate_0[BIT_SYNC_PORT1:BIT_SYNC_PORT0]))
        else $error("sync port clocks do not follow their enables");

    a_mod_write: assert property ( // [RULE5]
        @(posedge core_clk) disable iff (sys_rst)
        (wr_take && hit_gate0 && pstrb[0] && !in_stop &&
         pwdata[BIT_MODULATOR]) |=> ##1 periph_clk_en.grp0[BIT_MODULATOR])
        else $error("modulator clock not on two cycles after enable write");

    a_timer_group: assert property ( // [RULE7] [RULE8] [RULE9]
        @(posedge core_clk) disable iff (sys_rst)
        !in_stop |=> periph_clk_en.grp1 == $past(peripheral_clock_gate_1))
        else $error("timer clocks do not follow second enable register");

    a_stop_kills: assert property ( // [RULE11]
        @(posedge core_clk) disable iff (sys_rst)
        in_stop |=> (periph_clk_en == ($past(gate_all) & $past(keep_all))))
        else $error("clock enables wrong in Stop mode");

    a_keep_needs_en: assert property ( // [RULE12]
        @(posedge core_clk) disable iff (sys_rst)
        in_stop |=>
        ((periph_clk_en & $past(keep_all) & ~$past(gate_all)) ==
         32'h0000_0000))
        else $error("keep bit alone supplied a clock");

    a_wake_run: assert property ( // [RULE13]
        @(posedge core_clk) disable iff (sys_rst)
        (in_stop && wake) |=> !in_stop ##1 !in_stop_mode)
        else $error("qualified interrupt did not return to Run");

    a_sel_blocked: assert property ( // [RULE14]
        @(posedge core_clk) disable iff (sys_rst)
        (periph_sel_gated & ~periph_clk_en) == 32'h0000_0000)
        else $error("access passed to a peripheral with no clock");

    a_reserved_zero: assert property ( // [RULE6] [RULE10]
        @(posedge core_clk) disable iff (sys_rst)
        ((peripheral_clock_gate_0 & ~GATE0_MASK) == 16'h0000) &&
        ((peripheral_clock_gate_1 & ~GATE1_MASK) == 16'h0000))
        else $error("reserved enable bit stored");

    a_cmp_gate: assert property ( // [RULE19]
        @(posedge core_clk) disable iff (sys_rst)
        !in_stop |=>
        periph_clk_en.grp0[BIT_COMPARATOR_B:BIT_ANALOG_OUT0] ==
        $past(peripheral_clock_gate_0[BIT_COMPARATOR_B:BIT_ANALOG_OUT0]))
        else $error("comparator or analog output clocks off their enables");

    // The keep bits only matter in Stop, so they are checked there alone.
    a_keep_hi_map: assert property ( // [RULE17]
        @(posedge core_clk) disable iff (sys_rst)
        in_stop |=>
        periph_clk_en.grp0[BIT_COMPARATOR_B:BIT_ANALOG_OUT0] ==
        $past(peripheral_clock_gate_0[BIT_COMPARATOR_B:BIT_ANALOG_OUT0] &
              stop_clock_keep_0[BIT_COMPARATOR_B:BIT_ANALOG_OUT0]))
        else $error("comparator or analog output keep bits misapplied");

    a_keep_lo_map: assert property ( // [RULE20]
        @(posedge core_clk) disable iff (sys_rst)
        in_stop |=>
        (periph_clk_en.grp0[BIT_SYNC_PORT0] ==
         $past(peripheral_clock_gate_0[BIT_SYNC_PORT0] &
               stop_clock_keep_0[BIT_SYNC_PORT0])) &&
        (periph_clk_en.grp0[BIT_MODULATOR] ==
         $past(peripheral_clock_gate_0[BIT_MODULATOR] &
               stop_clock_keep_0[BIT_MODULATOR])))
        else $error("sync port 0 or modulator keep bit misapplied");

    a_stop_entry: assert property ( // [RULE11]
        @(posedge core_clk) disable iff (sys_rst)
        (stop_pulse && !in_stop && !wake) |=> in_stop)
        else $error("stop request did not enter Stop mode");

    a_apb_answer: assert property ( // [RULE21]
        @(posedge core_clk) disable iff (sys_rst)
        (access && !pready) |=> pready ##1 !pready)
        else $error("APB answer not exactly one wait state");

endmodule : pcg_clock_gating

// File: logic/pcg_pkg.sv
// Package of offsets, field positions and carrier types for clock gating.
package pcg_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register indices; byte address is four times the index.
    localparam logic [5:0] IDX_GATE0 = 6'h0C;
    localparam logic [5:0] IDX_GATE1 = 6'h0D;
    localparam logic [5:0] IDX_KEEP0 = 6'h0E;
    localparam logic [5:0] IDX_KEEP1 = 6'h0F;
    localparam logic [5:0] IDX_MODE  = 6'h20;
    localparam int         ADDR_LSB  = 2;
    localparam int         ADDR_W    = 8;

    ////////////////////////////////////////////////////////////////////////
    // Writable bits of each register and reset values.
    localparam logic [15:0] GATE0_MASK  = 16'hF47D;
    localparam logic [15:0] GATE1_MASK  = 16'h70FF;
    localparam logic [15:0] KEEP0_MASK  = 16'hF47D;
    localparam logic [15:0] KEEP1_MASK  = 16'h70FF;
    localparam logic [15:0] REG_RESET   = 16'h0000;

    ////////////////////////////////////////////////////////////////////////
    // Field positions in group 0 (enable and stop-keep share positions).
    localparam int BIT_COMPARATOR_B = 15;
    localparam int BIT_COMPARATOR_A = 14;
    localparam int BIT_ANALOG_OUT1  = 13;
    localparam int BIT_ANALOG_OUT0  = 12;
    localparam int BIT_ANALOG_CONV  = 10;
    localparam int BIT_TWO_WIRE     = 6;
    localparam int BIT_ASYNC_PORT1  = 5;
    localparam int BIT_ASYNC_PORT0  = 4;
    localparam int BIT_SYNC_PORT1   = 3;
    localparam int BIT_SYNC_PORT0   = 2;
    localparam int BIT_MODULATOR    = 0;

    // Field positions in group 1.
    localparam int BIT_INTERVAL_T2  = 14;
    localparam int BIT_INTERVAL_T1  = 13;
    localparam int BIT_INTERVAL_T0  = 12;
    localparam int BIT_TIMER_B_LO   = 4;
    localparam int BIT_TIMER_A_LO   = 0;

    // Mode register fields.
    localparam int BIT_MODE_STOP_REQ = 0;
    localparam int BIT_MODE_IN_STOP  = 1;

    ////////////////////////////////////////////////////////////////////////
    // Carriers.
    typedef struct packed {
        logic [15:0] grp1;
        logic [15:0] grp0;
    } pcg_pair_type;

    typedef enum logic {
        PCG_RUN,
        PCG_STOP
    } pcg_mode_type;

endpackage : pcg_pkg

// File: logic/pcg_stop_ctrl.sv
// Run and Stop mode sequencer with peripheral wake-up.
`timescale 1ns/1ps
module pcg_stop_ctrl
    import pcg_pkg::*;
(
    // Clock and reset.
    input  wire logic core_clk,
    input  wire logic sys_rst,
    // Mode requests.
    input  wire logic stop_go,
    input  wire logic wake,
    // Mode state.
    output logic      in_stop
);

    pcg_mode_type mode;
    pcg_mode_type next_mode;

    ////////////////////////////////////////////////////////////////////////
    // A wake in the same cycle as a stop request keeps the system running,
    // so an interrupt is never swallowed by the mode change.
    always_comb begin
        next_mode = mode;
        case (mode)
            PCG_RUN: begin
                if (stop_go && !wake) begin
                    next_mode = PCG_STOP;
                end
            end
            PCG_STOP: begin
                if (wake) begin
                    next_mode = PCG_RUN; // [RULE13]
                end
            end
            default: begin
                next_mode = PCG_RUN;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mode <= PCG_RUN;
        end else begin
            mode <= next_mode;
        end
    end

    assign in_stop = (mode == PCG_STOP);

endmodule : pcg_stop_ctrl

// File: logic/pcg_gate_bank.sv
// Registered per-peripheral clock enables and access gating.
`timescale 1ns/1ps
module pcg_gate_bank
    import pcg_pkg::*;
#(
    parameter int WIDTH = 32
) (
    // Clock and reset.
    input  wire logic             core_clk,
    input  wire logic             sys_rst,
    // Controls.
    input  wire logic [WIDTH-1:0] gate,
    input  wire logic [WIDTH-1:0] keep,
    input  wire logic             in_stop,
    // Peripheral access selects.
    input  wire logic [WIDTH-1:0] sel_in,
    // Results.
    output logic      [WIDTH-1:0] clk_en,
    output logic      [WIDTH-1:0] sel_out
);

    generate
        if (WIDTH < 1) begin : g_bad_width
            $error("pcg_gate_bank needs at least one lane");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // The enable is registered so that each gated clock sees a clean,
    // glitch-free level; the cost is one cycle of latency after a write.
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_lane
            wire lane_on;
            assign lane_on = gate[g] & (~in_stop | keep[g]); // [RULE12]
            always_ff @(posedge core_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    clk_en[g]  <= 1'b0;
                    sel_out[g] <= 1'b0;
                end else begin
                    clk_en[g]  <= lane_on; // [RULE11]
                    sel_out[g] <= sel_in[g] & lane_on; // [RULE14]
                end
            end
        end
    endgenerate

endmodule : pcg_gate_bank

// File: tb/tb_top.sv
// Self-checking bench for the peripheral clock gating block.
`timescale 1ns/1ps
module tb_top;
    import pcg_pkg::*;

    logic              core_clk;
    logic              sys_rst;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
    logic [3:0]        pstrb;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic              stop_req;
    pcg_pair_type      periph_irq;
    pcg_pair_type      periph_sel;
    pcg_pair_type      periph_clk_en;
    pcg_pair_type      periph_sel_gated;
    logic              in_stop_mode;
    logic [31:0]       rdv;
    logic              erv;
    logic [15:0]       seed;
    logic [15:0]       g0;
    logic [15:0]       g1;
    logic [15:0]       k0;
    logic [15:0]       k1;
    int                fails = 0;
    int                checks_done = 0;

    pcg_clock_gating i_pcg_clock_gating (
        .core_clk         (core_clk),
        .sys_rst          (sys_rst),
        .psel             (psel),
        .penable          (penable),
        .pwrite           (pwrite),
        .paddr            (paddr),
        .pwdata           (pwdata),
        .pstrb            (pstrb),
        .prdata           (prdata),
        .pready           (pready),
        .pslverr          (pslverr),
        .stop_req         (stop_req),
        .periph_irq       (periph_irq),
        .periph_sel       (periph_sel),
        .periph_clk_en    (periph_clk_en),
        .periph_sel_gated (periph_sel_gated),
        .in_stop_mode     (in_stop_mode)
    );

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    ////////////////////////////////////////////////////////////////////
    // Random source and expectations.
    function automatic logic [15:0] rnd();
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        return seed;
    endfunction : rnd

    // In Stop a lane runs only where both enable and keep are set.
    function automatic logic [31:0] lanes(input logic stop);
        return stop ? {g1 & k1, g0 & k0} : {g1, g0};
    endfunction : lanes

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask : tick

    ////////////////////////////////////////////////////////////////////
    // APB master; the request holds until pready is sampled high.
    task automatic apb(input logic [7:0] a, input logic w,
                       input logic [31:0] d, input logic [3:0] s,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) fails++;
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
        apb(a, 1'b1, d, s, rdv, erv);
    endtask : wr

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        apb(a, 1'b0, 32'h0, 4'hF, rdv, erv);
        check(rdv, exp);
    endtask : rchk

    task automatic wr_all();
        wr(8'h30, {16'h0, g0}, 4'hF);
        wr(8'h34, {16'h0, g1}, 4'hF);
        wr(8'h38, {16'h0, k0}, 4'hF);
        wr(8'h3C, {16'h0, k1}, 4'hF);
    endtask : wr_all

    task automatic wait_mode(input logic v);
        int n;
        n = 0;
        while (in_stop_mode !== v && n < 20) begin
            @(posedge core_clk);
            n++;
        end
    endtask : wait_mode

    task automatic results();
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : results

    // The tests take a few hundred cycles; this margin is generous.
    initial begin
        repeat (20000) @(posedge core_clk);
        fails++;
        results();
    end

    ////////////////////////////////////////////////////////////////////
    initial begin
        int i;
        int m;
        seed = 16'h005F;
        sys_rst = 1'b1;
        {psel, penable, pwrite, stop_req} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pstrb = 4'h0;
        periph_irq = 32'h0;
        periph_sel = 32'h0;
        repeat (4) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        check(periph_clk_en, 32'h0);
        for (i = 0; i < 4; i++) rchk(8'h30 + 8'(4 * i), 32'h0);
        $display("test reset done");

        for (i = 0; i < 8; i++) begin
            g0 = (i == 0) ? GATE0_MASK : rnd() & GATE0_MASK;
            g1 = (i == 0) ? GATE1_MASK : rnd() & GATE1_MASK;
            k0 = rnd() & KEEP0_MASK;
            k1 = rnd() & KEEP1_MASK;
            wr_all();
            rchk(8'h30, {16'h0, g0});
            rchk(8'h34, {16'h0, g1});
            rchk(8'h38, {16'h0, k0});
            rchk(8'h3C, {16'h0, k1});
            periph_sel <= {rnd(), rnd()};
            tick(3);
            check(periph_clk_en, lanes(1'b0));
            check(periph_sel_gated, periph_sel & lanes(1'b0));
        end
        $display("test map done");

        // Lane writes touch only the strobed byte.
        wr(8'h30, {16'h0, GATE0_MASK}, 4'h1);
        g0 = (g0 & 16'hFF00) | (GATE0_MASK & 16'h00FF);
        rchk(8'h30, {16'h0, g0});
        wr(8'h30, 32'h0, 4'h2);
        g0 = g0 & 16'h00FF;
        rchk(8'h30, {16'h0, g0});
        apb(8'h44, 1'b1, 32'hFFFF, 4'hF, rdv, erv);
        check(erv, 32'h1);
        apb(8'h31, 1'b0, 32'h0, 4'hF, rdv, erv);
        check(erv, 32'h1);
        check(rdv, 32'h0);
        rchk(8'h30, {16'h0, g0});
        $display("test strobe and refusal done");

        for (m = 0; m < 2; m++) begin
            g0 = (rnd() & GATE0_MASK) | 16'h0001;
            k0 = (rnd() & rnd() & KEEP0_MASK) | 16'h0001;
            g1 = rnd() & GATE1_MASK;
            k1 = rnd() & KEEP1_MASK;
            wr_all();
            periph_sel <= {k1, k0};
            if (m == 0) begin
                wr(8'h80, 32'h1, 4'hF);
            end else begin
                stop_req <= 1'b1;
                @(posedge core_clk);
                stop_req <= 1'b0;
            end
            wait_mode(1'b1);
            check(in_stop_mode, 32'h1);
            tick(3);
            check(periph_clk_en, lanes(1'b1));
            check(periph_sel_gated, lanes(1'b1));
            rchk(8'h80, 32'h2);
            // Interrupts from stopped lanes must not wake the core.
            periph_irq <= {g1 & ~k1, g0 & ~k0};
            tick(10);
            check(in_stop_mode, 32'h1);
            periph_irq <= 32'h1;
            wait_mode(1'b0);
            check(in_stop_mode, 32'h0);
            periph_irq <= 32'h0;
            tick(3);
            check(periph_clk_en, lanes(1'b0));
        end
        $display("test stop and wake done");

        sys_rst <= 1'b1;
        tick(4);
        sys_rst <= 1'b0;
        tick(1);
        check(periph_clk_en, 32'h0);
        rchk(8'h38, 32'h0);
        $display("test second reset done");
        results();
    end

endmodule : tb_top
